// file: src/backlight_pkg.sv
// Shared constants, types and reset values of the backlight register bank.
package backlight_pkg;

    localparam logic [6:0] DEVICE_ADDRESS     = 7'h27;
    localparam logic [3:0] ACK_SLOT           = 4'h8;
    localparam logic [3:0] LAST_DATA_BIT      = 4'h7;

    localparam logic [7:0] REG_BRIGHT_HIGH    = 8'h00;
    localparam logic [7:0] REG_BRIGHT_LOW     = 8'h01;
    localparam logic [7:0] REG_CONFIGURATION  = 8'h02;
    localparam logic [7:0] REG_LIGHT_LOAD     = 8'h03;
    localparam logic [7:0] REG_BOOST_MODE     = 8'h04;
    localparam logic [7:0] REG_STATUS         = 8'h10;

    localparam logic [7:0] RST_BRIGHT_HIGH    = 8'hff;
    localparam logic [2:0] RST_BRIGHT_LOW     = 3'h7;
    localparam logic [7:0] RST_CONFIGURATION  = 8'hff;
    localparam logic [7:0] RST_LIGHT_LOAD     = 8'h00;
    localparam logic [7:0] LIGHT_LOAD_DEFAULT = 8'h83;
    localparam logic [7:0] RST_BOOST_MODE     = 8'hfa;
    localparam logic [3:0] RST_STATUS_LIVE    = 4'hf;

    localparam int CFG_DIM_HI     = 7;
    localparam int CFG_DIM_LO     = 6;
    localparam int CFG_FAULT_EN   = 5;
    localparam int CFG_SHORT_EN   = 4;
    localparam int CFG_OVP_25V    = 3;
    localparam int CFG_DITHER_OFF = 2;
    localparam int CFG_CH1_EN     = 1;
    localparam int CFG_CH0_EN     = 0;
    localparam int BM_SLEW_HI     = 7;
    localparam int BM_SLEW_LO     = 6;
    localparam int BM_SYNC_SKIP   = 5;
    localparam int BM_ABS_EN      = 4;
    localparam int BM_FREQ_HI     = 3;

    localparam logic [9:0] PEAK_BASE_MA = 10'h078;
    localparam logic [9:0] PEAK_STEP_MA = 10'h016;
    localparam logic [9:0] PFM_BASE_MA  = 10'h03c;
    localparam logic [9:0] PFM_STEP_MA  = 10'h00b;
    localparam logic [5:0] DITHER_LO    = 6'h3c;
    localparam logic [5:0] DITHER_HI    = 6'h3d;

    typedef enum logic [1:0] {
        DIM_SW_I2C_LIN  = 2'h0,
        DIM_SW_I2C_LOG  = 2'h1,
        DIM_PWM_I2C_LIN = 2'h2,
        DIM_PWM_SW_LIN  = 2'h3
    } dim_source_e;

    typedef enum logic [5:0] {
        ST_IDLE    = 6'h01,
        ST_ADDR    = 6'h02,
        ST_POINTER = 6'h04,
        ST_WRITE   = 6'h08,
        ST_READ    = 6'h10,
        ST_IGNORE  = 6'h20
    } link_state_e;

    typedef struct packed {
        logic        over_temperature;
        logic        overvoltage_open;
        logic        short_circuit;
        logic        overcurrent_fault;
        logic        boost_pwm_mode;
        logic        leds_on;
        logic        led_channel_one_ok;
        logic        led_channel_zero_ok;
    } status_in_s;

    typedef struct packed {
        logic [10:0] brightness_code;
        dim_source_e dim_source;
        logic        faults_enable;
        logic        short_circuit_protection_enable;
        logic        overvoltage_limit_high;
        logic        dither_enable;
        logic        dither_active;
        logic        led_channel_one_enable;
        logic        led_channel_zero_enable;
        logic [1:0]  boost_slew;
        logic        sync_pulse_skip;
        logic        audio_band_suppression_enable;
        logic [3:0]  boost_freq_code;
        logic [9:0]  peak_current_ma;
        logic [9:0]  pfm_entry_current_ma;
    } ctrl_s;

    localparam ctrl_s CTRL_RESET = '{
        brightness_code:                 11'h7ff,
        dim_source:                      DIM_PWM_SW_LIN,
        faults_enable:                   1'b1,
        short_circuit_protection_enable: 1'b1,
        overvoltage_limit_high:          1'b1,
        dither_enable:                   1'b0,
        dither_active:                   1'b0,
        led_channel_one_enable:          1'b1,
        led_channel_zero_enable:         1'b1,
        boost_slew:                      2'h3,
        sync_pulse_skip:                 1'b1,
        audio_band_suppression_enable:   1'b1,
        boost_freq_code:                 4'ha,
        peak_current_ma:                 10'h128,
        pfm_entry_current_ma:            10'h05d
    };

endpackage : backlight_pkg

// file: src/sync2.sv
// Two-flip-flop synchroniser for a group of levels from another domain.
module sync2 import backlight_pkg::*; #(
    parameter int         WIDTH       = 1,
    parameter logic [9:0] RESET_VALUE = 10'h000
) (
    input  wire logic             sys_clk,
    input  wire logic             rst_b,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } sync_s;

    sync_s r;
    sync_s next_r;

    always_comb begin
        next_r.first  = d;
        next_r.second = r.first;
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            r <= {RESET_VALUE[WIDTH-1:0], RESET_VALUE[WIDTH-1:0]};
        end else begin
            r <= next_r;
        end
    end

    assign q = r.second;

endmodule : sync2

// file: src/link_shift.sv
// Serial-clock domain shifter that samples the data line on each rising clock.
module link_shift import backlight_pkg::*; (
    input  wire logic       scl_clk,
    input  wire logic       rst_b,
    input  wire logic       sda_in,
    output logic      [7:0] rx_byte
);

    typedef struct packed {
        logic [7:0] shift;
    } shift_s;

    shift_s r;
    shift_s next_r;

    always_comb begin
        next_r.shift = {r.shift[6:0], sda_in};
    end

    always_ff @(posedge scl_clk or negedge rst_b) begin
        if (!rst_b) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign rx_byte = r.shift;

endmodule : link_shift

// file: src/backlight_i2c_register_bank.sv
// Serial-bus slave and byte register bank of the two-channel backlight driver.
// How it works
// - Read address after restart keeps stored pointer.
// - Register byte shifted out most significant first.
// - Written byte applies after its eighth bit.
// - Reset loads every register default.
// - Low brightness bits wait for high write.
// - Light-load register ignored until first written.
// - Light-load nibbles give peak and entry currents.
// - Configuration bit three picks overvoltage limit.
// - Dither flags codes 60 and 61 mod 64.
// - Boost mode low nibble selects frequency.
// - Configuration bits seven six pick dimming source.
// - Boost mode bit five picks light-load behaviour.
module backlight_i2c_register_bank import backlight_pkg::*; (
    input  wire logic       sys_clk,
    input  wire logic       rst_b,
    input  wire logic       scl,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    input  wire status_in_s status_in,
    output ctrl_s           ctrl
);

    typedef struct packed {
        link_state_e state;
        logic [3:0]  bit_cnt;
        logic        scl_prev;
        logic        sda_prev;
        logic        ack_pending;
        logic        read_dir;
        logic [7:0]  pointer;
        logic [7:0]  tx;
        logic [7:0]  bright_high;
        logic [2:0]  bright_low_pending;
        logic [7:0]  configuration;
        logic [7:0]  light_load;
        logic        light_load_written;
        logic [7:0]  boost_mode;
        logic [3:0]  sticky;
        logic        sda_out;
        logic        sda_oe;
        ctrl_s       ctrl;
    } bank_s;

    localparam bank_s BANK_RESET = '{
        state:              ST_IDLE,
        bit_cnt:            4'h0,
        scl_prev:           1'b1,
        sda_prev:           1'b1,
        ack_pending:        1'b0,
        read_dir:           1'b0,
        pointer:            8'h00,
        tx:                 8'h00,
        bright_high:        RST_BRIGHT_HIGH,
        bright_low_pending: RST_BRIGHT_LOW,
        configuration:      RST_CONFIGURATION,
        light_load:         RST_LIGHT_LOAD,
        light_load_written: 1'b0,
        boost_mode:         RST_BOOST_MODE,
        sticky:             4'h0,
        sda_out:            1'b0,
        sda_oe:             1'b0,
        ctrl:               CTRL_RESET
    };

    logic [1:0]  rst_pipe;
    logic        rst_sync;
    logic [9:0]  sync_q;
    logic        scl_s;
    logic        sda_s;
    status_in_s  status_s;
    logic [7:0]  rx_byte;
    logic        rise;
    logic        fall;
    logic        start_seen;
    logic        stop_seen;
    logic        wr_en;
    logic [7:0]  ll_eff;
    bank_s       r;
    bank_s       next_r;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_sync = rst_pipe[1];

    sync2 #(
        .WIDTH       (10),
        .RESET_VALUE ({2'h3, 4'h0, RST_STATUS_LIVE})
    ) u_pin_sync (
        .sys_clk (sys_clk),
        .rst_b   (rst_sync),
        .d       ({scl, sda_in, status_in}),
        .q       (sync_q)
    );

    assign scl_s    = sync_q[9];
    assign sda_s    = sync_q[8];
    assign status_s = status_in_s'(sync_q[7:0]);

    link_shift u_link_shift (
        .scl_clk (scl),
        .rst_b   (rst_sync),
        .sda_in  (sda_in),
        .rx_byte (rx_byte)
    );

    assign rise       = scl_s && !r.scl_prev;
    assign fall       = !scl_s && r.scl_prev;
    assign start_seen = scl_s && r.scl_prev && r.sda_prev && !sda_s;
    assign stop_seen  = scl_s && r.scl_prev && !r.sda_prev && sda_s;
    assign wr_en      = rise && !start_seen && r.state == ST_WRITE
                        && r.bit_cnt == LAST_DATA_BIT;

    function automatic logic [7:0] read_reg(input bank_s      b,
                                            input logic [7:0] ptr,
                                            input status_in_s st);
        logic [7:0] v;
        v = 8'h00;
        unique case (ptr)
            REG_BRIGHT_HIGH:   v = b.bright_high;
            REG_BRIGHT_LOW:    v = {5'h00, b.bright_low_pending};
            REG_CONFIGURATION: v = b.configuration;
            REG_LIGHT_LOAD:    v = b.light_load_written ? b.light_load : LIGHT_LOAD_DEFAULT;
            REG_BOOST_MODE:    v = b.boost_mode;
            REG_STATUS:        v = {b.sticky, st[3:0]};
            default:           v = 8'h00;
        endcase
        return v;
    endfunction : read_reg

    always_comb begin
        logic [3:0] clr;
        clr = 4'h0;
        ll_eff = 8'h00;
        next_r = r;
        next_r.scl_prev = scl_s;
        next_r.sda_prev = sda_s;
        if (start_seen) begin
            next_r.state       = ST_ADDR;
            next_r.bit_cnt     = 4'h0;
            next_r.ack_pending = 1'b0;
            next_r.sda_oe      = 1'b0;
        end else if (stop_seen) begin
            next_r.state   = ST_IDLE;
            next_r.bit_cnt = 4'h0;
            next_r.sda_oe  = 1'b0;
        end else if (rise && r.state != ST_IDLE && r.state != ST_IGNORE) begin
            if (r.bit_cnt == ACK_SLOT) begin
                next_r.bit_cnt     = 4'h0;
                next_r.ack_pending = 1'b0;
                unique case (r.state)
                    ST_ADDR: begin
                        if (!r.ack_pending) begin
                            next_r.state = ST_IGNORE;
                        end else if (r.read_dir) begin
                            next_r.state = ST_READ;
                            next_r.tx    = read_reg(r, r.pointer, status_s);
                            clr          = (r.pointer == REG_STATUS) ? 4'hf : 4'h0;
                        end else begin
                            next_r.state = ST_POINTER;
                        end
                    end
                    ST_POINTER: next_r.state = ST_WRITE;
                    ST_WRITE:   next_r.state = ST_WRITE;
                    ST_READ: begin
                        if (!sda_s) begin
                            next_r.tx = read_reg(r, r.pointer, status_s);
                            clr       = (r.pointer == REG_STATUS) ? 4'hf : 4'h0;
                        end else begin
                            next_r.state = ST_IGNORE;
                        end
                    end
                    default: next_r.state = ST_IDLE;
                endcase
            end else begin
                next_r.bit_cnt = r.bit_cnt + 4'h1;
                if (r.bit_cnt == LAST_DATA_BIT) begin
                    unique case (r.state)
                        ST_ADDR: begin
                            next_r.ack_pending = rx_byte[7:1] == DEVICE_ADDRESS;
                            next_r.read_dir    = rx_byte[0];
                        end
                        ST_POINTER: begin
                            next_r.pointer     = rx_byte;
                            next_r.ack_pending = 1'b1;
                        end
                        ST_WRITE: next_r.ack_pending = 1'b1;
                        default:  next_r.ack_pending = 1'b0;
                    endcase
                end
            end
        end else if (fall) begin
            if (r.state == ST_READ) begin
                next_r.sda_oe = (r.bit_cnt < ACK_SLOT)
                                && !r.tx[3'h7 - r.bit_cnt[2:0]];
            end else begin
                next_r.sda_oe = (r.bit_cnt == ACK_SLOT) && r.ack_pending;
            end
        end
        if (wr_en) begin
            unique case (r.pointer)
                REG_BRIGHT_HIGH: begin
                    next_r.bright_high = rx_byte;
                    next_r.ctrl.brightness_code = {rx_byte, r.bright_low_pending};
                end
                REG_BRIGHT_LOW:    next_r.bright_low_pending = rx_byte[2:0];
                REG_CONFIGURATION: next_r.configuration = rx_byte;
                REG_LIGHT_LOAD: begin
                    next_r.light_load         = rx_byte;
                    next_r.light_load_written = 1'b1;
                end
                REG_BOOST_MODE:    next_r.boost_mode = rx_byte;
                default:           next_r.pointer = r.pointer;
            endcase
        end
        next_r.sticky = (r.sticky & ~clr) | status_s[7:4];
        next_r.ctrl.dim_source = dim_source_e'(
            next_r.configuration[CFG_DIM_HI:CFG_DIM_LO]);
        next_r.ctrl.faults_enable = next_r.configuration[CFG_FAULT_EN];
        next_r.ctrl.short_circuit_protection_enable = next_r.configuration[CFG_SHORT_EN];
        next_r.ctrl.overvoltage_limit_high = next_r.configuration[CFG_OVP_25V];
        next_r.ctrl.dither_enable = !next_r.configuration[CFG_DITHER_OFF];
        next_r.ctrl.dither_active = next_r.ctrl.dither_enable
            && (next_r.ctrl.brightness_code[5:0] == DITHER_LO
                || next_r.ctrl.brightness_code[5:0] == DITHER_HI);
        next_r.ctrl.led_channel_one_enable  = next_r.configuration[CFG_CH1_EN];
        next_r.ctrl.led_channel_zero_enable = next_r.configuration[CFG_CH0_EN];
        next_r.ctrl.boost_slew = next_r.boost_mode[BM_SLEW_HI:BM_SLEW_LO];
        next_r.ctrl.sync_pulse_skip = next_r.boost_mode[BM_SYNC_SKIP];
        next_r.ctrl.audio_band_suppression_enable = next_r.boost_mode[BM_ABS_EN];
        next_r.ctrl.boost_freq_code = next_r.boost_mode[BM_FREQ_HI:0];
        ll_eff = next_r.light_load_written ? next_r.light_load : LIGHT_LOAD_DEFAULT;
        next_r.ctrl.peak_current_ma = PEAK_BASE_MA
            + PEAK_STEP_MA * {6'h00, ll_eff[7:4]};
        next_r.ctrl.pfm_entry_current_ma = PFM_BASE_MA
            + PFM_STEP_MA * {6'h00, ll_eff[3:0]};
    end

    always_ff @(posedge sys_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            r <= BANK_RESET;
        end else begin
            r <= next_r;
        end
    end

    assign sda_out = r.sda_out;
    assign sda_oe  = r.sda_oe;
    assign ctrl    = r.ctrl;

    property p_low_pending;
        @(posedge sys_clk) disable iff (!rst_sync)
        wr_en && r.pointer == REG_BRIGHT_LOW |=> $stable(ctrl.brightness_code);
    endproperty
    a_low_pending: assert property (p_low_pending)
        else $error("Low brightness write changed the applied code.");

    property p_high_applies;
        @(posedge sys_clk) disable iff (!rst_sync)
        wr_en && r.pointer == REG_BRIGHT_HIGH |=>
            ctrl.brightness_code == {$past(rx_byte), $past(r.bright_low_pending)};
    endproperty
    a_high_applies: assert property (p_high_applies)
        else $error("High brightness write did not apply the full code.");

    property p_write_eighth_bit;
        @(posedge sys_clk) disable iff (!rst_sync)
        $changed(r.configuration) |-> $past(r.bit_cnt) == LAST_DATA_BIT
            && $past(r.state) == ST_WRITE && $past(rise);
    endproperty
    a_write_eighth_bit: assert property (p_write_eighth_bit)
        else $error("Register changed other than at the eighth data bit.");

    property p_light_load_default;
        @(posedge sys_clk) disable iff (!rst_sync)
        !r.light_load_written |-> ctrl.pfm_entry_current_ma == CTRL_RESET.pfm_entry_current_ma;
    endproperty
    a_light_load_default: assert property (p_light_load_default)
        else $error("Unwritten light-load register did not give defaults.");

    property p_peak_current;
        @(posedge sys_clk) disable iff (!rst_sync)
        r.light_load_written |-> ctrl.peak_current_ma
            == PEAK_BASE_MA + PEAK_STEP_MA * {6'h00, r.light_load[7:4]};
    endproperty
    a_peak_current: assert property (p_peak_current)
        else $error("Peak current does not follow the light-load upper nibble.");

    property p_ovp_select;
        @(posedge sys_clk) disable iff (!rst_sync)
        ctrl.overvoltage_limit_high == r.configuration[CFG_OVP_25V];
    endproperty
    a_ovp_select: assert property (p_ovp_select)
        else $error("Overvoltage limit differs from configuration bit.");

    property p_dither_codes;
        @(posedge sys_clk) disable iff (!rst_sync)
        ctrl.dither_active |-> ctrl.brightness_code[5:1] == 5'h1e
            && !r.configuration[CFG_DITHER_OFF];
    endproperty
    a_dither_codes: assert property (p_dither_codes)
        else $error("Dither active outside its codes or while disabled.");

    property p_msb_first;
        @(posedge sys_clk) disable iff (!rst_sync)
        fall && !start_seen && !stop_seen && r.state == ST_READ && r.bit_cnt == 4'h0
            |=> r.sda_oe == !r.tx[7];
    endproperty
    a_msb_first: assert property (p_msb_first)
        else $error("First read bit is not the most significant bit.");

    property p_pointer_kept;
        @(posedge sys_clk) disable iff (!rst_sync)
        rise && !start_seen && r.state == ST_ADDR && r.bit_cnt == ACK_SLOT
            && r.ack_pending && r.read_dir
            |=> r.state == ST_READ && $stable(r.pointer)
                && r.tx == $past(read_reg(r, r.pointer, status_s));
    endproperty
    a_pointer_kept: assert property (p_pointer_kept)
        else $error("Read did not start from the stored pointer.");

    property p_sticky_set_wins;
        @(posedge sys_clk) disable iff (!rst_sync)
        status_s[7:4] != 4'h0 |=> (r.sticky & $past(status_s[7:4])) == $past(status_s[7:4]);
    endproperty
    a_sticky_set_wins: assert property (p_sticky_set_wins)
        else $error("A fault event was lost from the sticky flags.");

    property p_reset_defaults;
        @(posedge sys_clk) disable iff (!rst_sync)
        $rose(rst_sync) |-> r.boost_mode == RST_BOOST_MODE && ctrl == CTRL_RESET;
    endproperty
    a_reset_defaults: assert property (p_reset_defaults)
        else $error("Registers did not hold defaults after reset.");

endmodule : backlight_i2c_register_bank

// file: testbench/i2c_master_model.sv
// Serial-bus master model that runs frames on the clock and data lines.
module i2c_master_model (
    input  wire logic sda_wire,
    output logic      scl,
    output logic      sda_pull
);
    timeunit 1ns;
    timeprecision 1ps;

    logic link_clk = 1'b0;

    // The clock line stands high between frames; each phase lasts two 80 ns ticks, 160 ns.
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
        #5;
        forever #40 link_clk = ~link_clk;
    end

    task automatic wait_q();
        repeat (2) @(posedge link_clk);
        #2;
    endtask : wait_q

    // Start or repeated start: data falls while the clock is high.
    task automatic start();
        sda_pull = 1'b0;
        wait_q();
        scl = 1'b1;
        wait_q();
        sda_pull = 1'b1;
        wait_q();
        scl = 1'b0;
        wait_q();
    endtask : start

    // Stop: data rises while the clock is high.
    task automatic stop();
        sda_pull = 1'b1;
        wait_q();
        scl = 1'b1;
        wait_q();
        sda_pull = 1'b0;
        wait_q();
    endtask : stop

    // Data changes only in the low phase, well after the falling clock.
    task automatic xfer_bit(input logic b, output logic r);
        sda_pull = !b;
        wait_q();
        scl = 1'b1;
        wait_q();
        r = sda_wire;
        scl = 1'b0;
        wait_q();
    endtask : xfer_bit

    task automatic send(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(d[i], r);
        end
        xfer_bit(1'b1, r);
        ack = !r;
    endtask : send

    task automatic recv(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(1'b1, r);
            d[i] = r;
        end
        xfer_bit(last, r);
    endtask : recv
endmodule : i2c_master_model

// file: testbench/tb_top.sv
// Self-checking bench of the backlight register bank.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import backlight_pkg::*;

    logic       sys_clk    = 1'b0;
    logic       rst_b      = 1'b0;
    logic       scl;
    logic       sda_pull;
    logic       sda_out;
    logic       sda_oe;
    logic       sda_wire;
    status_in_s status_in  = 8'h05;
    ctrl_s      ctrl;
    int         num_errors = 0;
    int         n_checks   = 0;
    int         cycles     = 0;
    logic       ack;
    logic [7:0] rd;
    logic [15:0] defs [6]  = '{16'h00ff, 16'h0107, 16'h02ff, 16'h0383, 16'h04fa, 16'h1005};
    logic [7:0] bm [2]     = '{8'h0b, 8'h20};

    // The data line has a pull-up; either party may pull it low.
    assign sda_wire = !sda_pull && (sda_oe ? sda_out : 1'b1);

    backlight_i2c_register_bank dut (
        .sys_clk  (sys_clk),
        .rst_b    (rst_b),
        .scl      (scl),
        .sda_in   (sda_wire),
        .sda_out  (sda_out),
        .sda_oe   (sda_oe),
        .status_in(status_in),
        .ctrl     (ctrl)
    );

    i2c_master_model m (
        .sda_wire(sda_wire),
        .scl     (scl),
        .sda_pull(sda_pull)
    );

    always #10 sys_clk = ~sys_clk;

    task automatic final_report();
        if (num_errors == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : final_report

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            num_errors++;
            final_report();
        end
    end

    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] ptr, input logic [7:0] val);
        m.start();
        m.send({DEVICE_ADDRESS, 1'b0}, ack);
        chk(ack, 1'b1);
        m.send(ptr, ack);
        m.send(val, ack);
        chk(ack, 1'b1);
        m.stop();
    endtask : wr

    task automatic rchk(input logic [7:0] ptr, input logic use_stop, input logic [7:0] exp);
        m.start();
        m.send({DEVICE_ADDRESS, 1'b0}, ack);
        m.send(ptr, ack);
        chk(ack, 1'b1);
        if (use_stop) begin
            m.stop();
        end
        m.start();
        m.send({DEVICE_ADDRESS, 1'b1}, ack);
        chk(ack, 1'b1);
        m.recv(1'b1, rd);
        m.stop();
        chk(rd, exp);
    endtask : rchk

    initial begin
        repeat (3) @(posedge sys_clk);
        #2 rst_b = 1'b1;
        repeat (8) @(posedge sys_clk);
        #2 chk(ctrl, CTRL_RESET);
        foreach (defs[i]) begin
            rchk(defs[i][15:8], 1'b0, defs[i][7:0]);
        end
        for (int i = 0; i < 4; i++) begin
            wr(REG_CONFIGURATION, {i[1:0], 6'h00});
            chk(ctrl.dim_source, i[1:0]);
            chk(ctrl.overvoltage_limit_high, 1'b0);
            chk(ctrl.dither_enable, 1'b1);
        end
        wr(REG_BRIGHT_LOW, 8'h04);
        chk(ctrl.brightness_code, CTRL_RESET.brightness_code);
        wr(REG_BRIGHT_HIGH, 8'h07);
        chk(ctrl.brightness_code, 11'h03c);
        chk(ctrl.dither_active, 1'b1);
        rchk(REG_BRIGHT_LOW, 1'b1, 8'h04);
        m.start();
        m.send({DEVICE_ADDRESS, 1'b0}, ack);
        m.send(REG_LIGHT_LOAD, ack);
        m.send(8'h21, ack);
        chk(ctrl.peak_current_ma, PEAK_BASE_MA + 2 * PEAK_STEP_MA);
        chk(ctrl.pfm_entry_current_ma, PFM_BASE_MA + PFM_STEP_MA);
        m.stop();
        foreach (bm[i]) begin
            wr(REG_BOOST_MODE, bm[i]);
            chk(ctrl.boost_freq_code, bm[i][3:0]);
            chk(ctrl.sync_pulse_skip, bm[i][5]);
        end
        @(posedge sys_clk);
        #2 status_in.over_temperature = 1'b1;
        repeat (10) @(posedge sys_clk);
        #2 status_in.over_temperature = 1'b0;
        rchk(REG_STATUS, 1'b0, 8'h85);
        wr(REG_STATUS, 8'h5a);
        rchk(REG_STATUS, 1'b0, 8'h05);
        rchk(8'h20, 1'b0, 8'h00);
        m.start();
        m.send(8'h50, ack);
        chk(ack, 1'b0);
        m.stop();
        @(posedge sys_clk);
        #2 rst_b = 1'b0;
        @(posedge sys_clk);
        #2 chk(ctrl, CTRL_RESET);
        rst_b = 1'b1;
        repeat (8) @(posedge sys_clk);
        rchk(REG_LIGHT_LOAD, 1'b0, LIGHT_LOAD_DEFAULT);
        final_report();
    end
endmodule : tb_top
